// >>> pkg/hmp_pkg.sv
// Constants, field layouts, states and carriers of the host memory access port
package hmp_pkg;

    // Host bus field layout during an address latch
    localparam int ADDR_W = 14;
    localparam int BUS_W = 16;
    localparam int PM_W = 24;
    localparam int LOW_W = 8;
    localparam int SPACE_BIT = 14;
    localparam int OVL_BIT = 15;
    localparam int OVL_W = 8;

    // Synchronised strobe vector positions
    localparam int CTL_W = 4;
    localparam int CTL_SEL = 0;
    localparam int CTL_ALE = 1;
    localparam int CTL_RD = 2;
    localparam int CTL_WR = 3;

    // First shielded data memory location: control registers live from here up
    localparam logic [ADDR_W-1:0] CTRL_REG_BASE = 14'h3fe0;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 14'h0001;

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 14'h0000;
    localparam logic [OVL_W-1:0] OVL_RST = 8'h00;
    localparam logic [BUS_W-1:0] BUS_RST = 16'h0000;
    localparam logic [PM_W-1:0] WORD_RST = 24'h00_0000;
    localparam logic [LOW_W-1:0] LOW_RST = 8'h00;
    localparam logic [CTL_W-1:0] CTL_IDLE = 4'h0;

    typedef enum logic [2:0] {
        HMP_IDLE = 3'b000,
        HMP_WAIT_RD = 3'b001,
        HMP_MEM_RD = 3'b010,
        HMP_CAP_RD = 3'b011,
        HMP_HALF_RD = 3'b100,
        HMP_WAIT_WR = 3'b101,
        HMP_HALF_WR = 3'b110,
        HMP_DONE = 3'b111
    } hmp_fsm_t;

    // Request toward internal memory; read data returns one cycle after req
    typedef struct packed {
        logic req;
        logic we;
        logic pm;
        logic [ADDR_W-1:0] addr;
        logic [PM_W-1:0] wdata;
    } hmp_mem_req_t;

    // Core view of the transfer address register
    typedef struct packed {
        logic pm;
        logic [ADDR_W-1:0] addr;
    } hmp_ctrl_t;

    typedef struct packed {
        logic [CTL_W-1:0] ctl_s1;
        logic [CTL_W-1:0] ctl_s2;
        logic [BUS_W-1:0] bus_s1;
        logic [BUS_W-1:0] bus_s2;
        hmp_fsm_t fsm;
        logic [ADDR_W-1:0] addr;
        logic pm;
        logic [OVL_W-1:0] ovl;
        logic pend_rd;
        logic pend_wr;
        logic [LOW_W-1:0] hold_lo;
        logic [BUS_W-1:0] hold_hi;
        logic [PM_W-1:0] wword;
        logic [BUS_W-1:0] rdata;
        logic rd_oe;
    } hmp_state_t;

endpackage

// >>> hdl/hmp_host_memory_port.sv
// Host memory access port: host strobes, transfer address and memory cycle stealing
// Operation
// - Select plus latch captures starting address
// - Host cannot read back latched address
// - Address advances after each data word and after each full program word
// - Core stalls only for stolen memory cycle
// - Address wraps from top to zero
// - Latched address persists until rewritten
// - Core reads and writes transfer address
// - Program word read takes two accesses
// - Address rewrite drops pending read half
// - Address rewrite drops partial program write
// - Control register locations shielded from host
// - Upper sixteen first, then low byte zero-padded
// - Latch bits: address, space, bit15 zero
// - Bit15 set latches overlay page register
// - Acknowledge low idle, high while busy
`timescale 1ns/100ps
`default_nettype none

module hmp_host_memory_port (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host pins
    input wire logic port_select_n,
    input wire logic address_latch_enable,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [hmp_pkg::BUS_W-1:0] addr_data_bus_in,
    output logic [hmp_pkg::BUS_W-1:0] addr_data_bus_out,
    output logic addr_data_bus_oe,
    output logic access_ack_n,
    // Core access to the transfer address register and overlay page
    input wire logic core_ctrl_we,
    input wire hmp_pkg::hmp_ctrl_t core_ctrl_wdata,
    output hmp_pkg::hmp_ctrl_t core_ctrl_rdata,
    output logic [hmp_pkg::OVL_W-1:0] overlay_page,
    // Internal memory and core pipeline
    input wire logic instr_boundary,
    output hmp_pkg::hmp_mem_req_t mem_req,
    input wire logic [hmp_pkg::PM_W-1:0] mem_rdata,
    output logic core_stall
);

    logic [1:0] rst_sync;
    logic rst_n;
    hmp_pkg::hmp_state_t st;
    hmp_pkg::hmp_state_t next_st;
    logic sel;
    logic ale;
    logic rd;
    logic wr;
    logic blocked;
    logic issue;
    logic [hmp_pkg::ADDR_W-1:0] addr_inc;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    // Decoded strobes come only from the second synchroniser stage
    assign sel = st.ctl_s2[hmp_pkg::CTL_SEL];
    assign ale = st.ctl_s2[hmp_pkg::CTL_ALE];
    assign rd = st.ctl_s2[hmp_pkg::CTL_RD];
    assign wr = st.ctl_s2[hmp_pkg::CTL_WR];

    // Control register block sits at the top of data memory
    assign blocked = !st.pm && (st.addr >= hmp_pkg::CTRL_REG_BASE);

    // Plain 14-bit increment rolls 0x3fff over to 0x0000
    assign addr_inc = st.addr + hmp_pkg::ADDR_ONE;

    // A memory cycle is stolen only at an instruction boundary
    assign issue = instr_boundary && !blocked;

    always_comb begin
        next_st = st;

        // Bus data is sampled alongside the strobes so both stay aligned
        next_st.ctl_s1 = {!write_strobe_n, !read_strobe_n, address_latch_enable,
                          !port_select_n};
        next_st.ctl_s2 = st.ctl_s1;
        next_st.bus_s1 = addr_data_bus_in;
        next_st.bus_s2 = st.bus_s1;

        // Drive the last fetched word for the whole read strobe; short reads rely on it
        next_st.rd_oe = sel && rd;

        case (st.fsm)
            hmp_pkg::HMP_IDLE: begin
                if (sel && ale && !rd && !wr) begin
                    next_st.fsm = hmp_pkg::HMP_DONE;
                    if (st.bus_s2[hmp_pkg::OVL_BIT]) begin
                        next_st.ovl = st.bus_s2[hmp_pkg::OVL_W-1:0];
                    end else begin
                        next_st.addr = st.bus_s2[hmp_pkg::ADDR_W-1:0];
                        next_st.pm = st.bus_s2[hmp_pkg::SPACE_BIT];
                        next_st.pend_rd = 1'b0;
                        next_st.pend_wr = 1'b0;
                    end
                end else if (sel && rd) begin
                    if (st.pm && st.pend_rd) begin
                        next_st.fsm = hmp_pkg::HMP_HALF_RD;
                    end else begin
                        next_st.fsm = hmp_pkg::HMP_WAIT_RD;
                    end
                end else if (sel && wr) begin
                    if (st.pm && !st.pend_wr) begin
                        next_st.hold_hi = st.bus_s2;
                        next_st.fsm = hmp_pkg::HMP_HALF_WR;
                    end else if (st.pm) begin
                        // Upper bits of the second half are ignored
                        next_st.wword = {st.hold_hi, st.bus_s2[hmp_pkg::LOW_W-1:0]};
                        next_st.fsm = hmp_pkg::HMP_WAIT_WR;
                    end else begin
                        next_st.wword = {hmp_pkg::LOW_RST, st.bus_s2};
                        next_st.fsm = hmp_pkg::HMP_WAIT_WR;
                    end
                end
            end
            hmp_pkg::HMP_WAIT_RD: begin
                if (issue) begin
                    next_st.fsm = hmp_pkg::HMP_MEM_RD;
                end else if (blocked) begin
                    next_st.fsm = hmp_pkg::HMP_CAP_RD;
                end
            end
            hmp_pkg::HMP_MEM_RD: begin
                next_st.fsm = hmp_pkg::HMP_CAP_RD;
            end
            hmp_pkg::HMP_CAP_RD: begin
                next_st.fsm = hmp_pkg::HMP_DONE;
                if (blocked) begin
                    next_st.rdata = hmp_pkg::BUS_RST;
                    next_st.addr = addr_inc;
                end else if (st.pm) begin
                    next_st.rdata = mem_rdata[hmp_pkg::PM_W-1:hmp_pkg::LOW_W];
                    next_st.hold_lo = mem_rdata[hmp_pkg::LOW_W-1:0];
                    next_st.pend_rd = 1'b1;
                end else begin
                    next_st.rdata = mem_rdata[hmp_pkg::BUS_W-1:0];
                    next_st.addr = addr_inc;
                end
            end
            hmp_pkg::HMP_HALF_RD: begin
                // Second half needs no memory cycle and no boundary wait
                next_st.rdata = {hmp_pkg::LOW_RST, st.hold_lo};
                next_st.pend_rd = 1'b0;
                next_st.addr = addr_inc;
                next_st.fsm = hmp_pkg::HMP_DONE;
            end
            hmp_pkg::HMP_WAIT_WR: begin
                if (issue || blocked) begin
                    // Blocked writes are dropped but still advance the address
                    next_st.pend_wr = 1'b0;
                    next_st.addr = addr_inc;
                    next_st.fsm = hmp_pkg::HMP_DONE;
                end
            end
            hmp_pkg::HMP_HALF_WR: begin
                next_st.pend_wr = 1'b1;
                next_st.fsm = hmp_pkg::HMP_DONE;
            end
            hmp_pkg::HMP_DONE: begin
                // Hold here until the host ends the access, so one strobe is one transfer
                if (!sel || (!ale && !rd && !wr)) begin
                    next_st.fsm = hmp_pkg::HMP_IDLE;
                end
            end
            default: begin
                next_st.fsm = hmp_pkg::HMP_IDLE;
            end
        endcase

        // Core write overrides any increment in the same cycle
        if (core_ctrl_we) begin
            next_st.addr = core_ctrl_wdata.addr;
            next_st.pm = core_ctrl_wdata.pm;
            next_st.pend_rd = 1'b0;
            next_st.pend_wr = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st.ctl_s1 <= hmp_pkg::CTL_IDLE;
            st.ctl_s2 <= hmp_pkg::CTL_IDLE;
            st.bus_s1 <= hmp_pkg::BUS_RST;
            st.bus_s2 <= hmp_pkg::BUS_RST;
            st.fsm <= hmp_pkg::HMP_IDLE;
            st.addr <= hmp_pkg::ADDR_RST;
            st.pm <= 1'b0;
            st.ovl <= hmp_pkg::OVL_RST;
            st.pend_rd <= 1'b0;
            st.pend_wr <= 1'b0;
            st.hold_lo <= hmp_pkg::LOW_RST;
            st.hold_hi <= hmp_pkg::BUS_RST;
            st.wword <= hmp_pkg::WORD_RST;
            st.rdata <= hmp_pkg::BUS_RST;
            st.rd_oe <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // Busy from the first synchronised strobe until the operation completes
    assign access_ack_n = (st.fsm != hmp_pkg::HMP_IDLE) &&
                          (st.fsm != hmp_pkg::HMP_DONE);

    // Host bus carries memory data, or zero for shielded reads, never the address register
    assign addr_data_bus_out = st.rdata;
    assign addr_data_bus_oe = st.rd_oe;

    assign core_ctrl_rdata.pm = st.pm;
    assign core_ctrl_rdata.addr = st.addr;
    assign overlay_page = st.ovl;

    // Exactly one stolen cycle per memory access
    assign mem_req.req = ((st.fsm == hmp_pkg::HMP_MEM_RD) ||
                          ((st.fsm == hmp_pkg::HMP_WAIT_WR) && issue));
    assign mem_req.we = (st.fsm == hmp_pkg::HMP_WAIT_WR);
    assign mem_req.pm = st.pm;
    assign mem_req.addr = st.addr;
    assign mem_req.wdata = st.wword;
    assign core_stall = mem_req.req;

endmodule

`default_nettype wire

// >>> bench/hmp_host_model.sv
// Host stand-in: drives select, latch and strobes, paced by acknowledge
`timescale 1ns/100ps
`default_nettype none
module hmp_host_model (
    // Clock
    input wire logic clk,
    // Host pins
    output logic port_select_n,
    output logic address_latch_enable,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [15:0] bus,
    input wire logic [15:0] rd_bus,
    input wire logic access_ack_n
);
    int n_hang = 0;
    initial begin
        port_select_n = 1'b1;
        address_latch_enable = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        bus = 16'hffff;
    end
    // Kind 0 latches, 1 reads, 2 writes, 3 short reads; a latch never raises acknowledge
    task automatic xfer(input logic [1:0] k, input logic [15:0] v, output logic [15:0] r);
        int i;
        i = 0;
        while (access_ack_n !== 1'b0 && i < 99) begin
            @(negedge clk);
            i++;
        end
        @(posedge clk);
        port_select_n <= 1'b0;
        address_latch_enable <= (k == 2'h0);
        read_strobe_n <= !(k == 2'h1 || k == 2'h3);
        write_strobe_n <= (k != 2'h2);
        bus <= v;
        if (k == 2'h0) repeat (6) @(negedge clk);
        while (k != 2'h0 && access_ack_n !== 1'b1 && i < 99) begin
            @(negedge clk);
            i++;
        end
        if (k != 2'h0 && access_ack_n !== 1'b1) n_hang++;
        // Short read takes the previous word and leaves before the fetch completes
        while (k != 2'h3 && access_ack_n !== 1'b0 && i < 199) begin
            @(negedge clk);
            i++;
        end
        if (i >= 199) n_hang++;
        r = rd_bus;
        @(posedge clk);
        port_select_n <= 1'b1;
        address_latch_enable <= 1'b0;
        read_strobe_n <= 1'b1;
        write_strobe_n <= 1'b1;
        bus <= ~v; // Released bus must not keep the last value
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> bench/hmp_host_memory_port_asserts.sv
// Pin-level checks of the host memory port
`timescale 1ns/100ps
`default_nettype none
module hmp_host_memory_port_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host pins
    input wire logic port_select_n,
    input wire logic address_latch_enable,
    input wire logic read_strobe_n,
    input wire logic addr_data_bus_oe,
    input wire logic access_ack_n,
    // Core and memory side
    input wire logic core_ctrl_we,
    input wire hmp_pkg::hmp_ctrl_t core_ctrl_wdata,
    input wire hmp_pkg::hmp_ctrl_t core_ctrl_rdata,
    input wire logic [hmp_pkg::OVL_W-1:0] overlay_page,
    input wire hmp_pkg::hmp_mem_req_t mem_req,
    input wire logic core_stall
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_ack_back;
        ##[1:40] !access_ack_n;
    endsequence
    sequence s_sel_seen;
        !$past(port_select_n, 2) || !$past(port_select_n, 3);
    endsequence
    chk_stall_when_busy: assert property (core_stall |-> mem_req.req && access_ack_n)
        else $error("stall outside a busy access");
    chk_one_stolen: assert property (mem_req.req |=> !mem_req.req)
        else $error("stolen cycle too long");
    chk_busy_ends: assert property ($rose(access_ack_n) |-> s_ack_back)
        else $error("busy never ends");
    chk_busy_cause: assert property ($rose(access_ack_n) |-> s_sel_seen)
        else $error("busy without select");
    chk_shield_dm: assert property (mem_req.req && !mem_req.pm |->
        mem_req.addr < hmp_pkg::CTRL_REG_BASE) else $error("shielded access");
    chk_oe_on_read: assert property (addr_data_bus_oe |->
        !$past(read_strobe_n, 3) && !$past(port_select_n, 3)) else $error("bad drive");
    chk_ovl_by_latch: assert property ($changed(overlay_page) |->
        $past(address_latch_enable, 2) || $past(address_latch_enable, 3))
        else $error("overlay changed");
    chk_core_write: assert property (core_ctrl_we && port_select_n && $past(port_select_n)
        && $past(port_select_n, 2) && $past(port_select_n, 3)
        |=> core_ctrl_rdata == $past(core_ctrl_wdata)) else $error("core write lost");
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Bench top: clock, reset, memory stand-in and port scenarios
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %0t: got %h want %h", $time, g, e); end end
module tb_top;
    logic clk, nrst, sel_n, ale, rd_n, wr_n, oe, ack_n, we, bnd, stall;
    logic [15:0] hbus, bus_in, bus_out, d;
    logic [23:0] mem_rdata;
    logic [7:0] ovl;
    logic [1:0] bcnt;
    hmp_pkg::hmp_ctrl_t wdat, rdat;
    hmp_pkg::hmp_mem_req_t mreq;
    logic [23:0] mem_pm [0:16383];
    logic [15:0] mem_dm [0:16383];
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;
    assign bus_in = oe ? bus_out : hbus;
    hmp_host_memory_port i_dut (.clk(clk), .nrst(nrst), .port_select_n(sel_n),
        .address_latch_enable(ale), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .addr_data_bus_in(bus_in), .addr_data_bus_out(bus_out), .addr_data_bus_oe(oe),
        .access_ack_n(ack_n), .core_ctrl_we(we), .core_ctrl_wdata(wdat),
        .core_ctrl_rdata(rdat), .overlay_page(ovl), .instr_boundary(bnd), .mem_req(mreq),
        .mem_rdata(mem_rdata), .core_stall(stall));
    hmp_host_model i_host (.clk(clk), .port_select_n(sel_n), .address_latch_enable(ale),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .bus(hbus), .rd_bus(bus_out),
        .access_ack_n(ack_n));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Boundary drops one cycle in four so stolen cycles must wait
    always @(posedge clk) begin
        bcnt <= bcnt + 2'h1;
        bnd <= (bcnt != 2'h3);
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
        if (mreq.req && mreq.we && mreq.pm) mem_pm[mreq.addr] <= mreq.wdata;
        if (mreq.req && mreq.we && !mreq.pm) mem_dm[mreq.addr] <= mreq.wdata[15:0];
        mem_rdata <= mreq.pm ? mem_pm[mreq.addr] : {8'h00, mem_dm[mreq.addr]};
    end
    task automatic x(input logic [1:0] k, input logic [15:0] v);
        i_host.xfer(k, v, d);
    endtask
    task automatic t_dm();
        `CHK(ack_n, 1'b0)
        x(2'h0, 16'h0010);
        `CHK(rdat, 15'h0010)
        x(2'h2, 16'ha5a5);
        x(2'h2, 16'h5a5a);
        `CHK(mem_dm[14'h0011], 16'h5a5a)
        `CHK(rdat, 15'h0012)
        x(2'h0, 16'h0010);
        x(2'h1, 16'h0000);
        `CHK(d, 16'ha5a5)
        x(2'h3, 16'h0000);
        `CHK(d, 16'ha5a5)
        x(2'h3, 16'h0000);
        `CHK(d, 16'h5a5a)
    endtask
    task automatic t_pm();
        x(2'h0, 16'h7fff);
        x(2'h2, 16'h1234);
        x(2'h2, 16'hff56);
        `CHK(mem_pm[14'h3fff], 24'h12_3456)
        `CHK(rdat, 15'h4000)
        x(2'h0, 16'h7fff);
        x(2'h1, 16'h0000);
        `CHK(d, 16'h1234)
        x(2'h1, 16'h0000);
        `CHK(d, 16'h0056)
    endtask
    task automatic t_drop();
        x(2'h0, 16'h4005);
        x(2'h1, 16'h0000);
        x(2'h0, 16'h4006);
        x(2'h1, 16'h0000);
        `CHK(d, 16'h1122)
        x(2'h0, 16'h4007);
        x(2'h2, 16'h9999);
        x(2'h0, 16'h4007);
        x(2'h2, 16'h4242);
        `CHK(mem_pm[14'h0007], 24'hdd_eeff)
        x(2'h2, 16'hff77);
        `CHK(mem_pm[14'h0007], 24'h42_4277)
    endtask
    task automatic t_misc();
        x(2'h0, 16'h3fe0);
        x(2'h1, 16'h0000);
        `CHK(d, 16'h0000)
        x(2'h0, 16'h3fe0);
        x(2'h2, 16'h1111);
        `CHK(mem_dm[14'h3fe0], 16'hbeef)
        x(2'h0, 16'h8034);
        `CHK(ovl, 8'h34)
        `CHK(rdat, 15'h3fe1)
        we <= 1'b1;
        wdat <= 15'h0020;
        @(posedge clk);
        we <= 1'b0;
        repeat (30) @(posedge clk);
        x(2'h1, 16'h0000);
        `CHK(d, 16'hc0de)
    endtask
    task automatic tally_and_finish();
        n_fail += i_host.n_hang;
        if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        nrst = 1'b0;
        we = 1'b0;
        wdat = 15'h0000;
        bnd = 1'b0;
        bcnt = 2'h0;
        mem_rdata = 24'h00_0000;
        mem_pm[5] = 24'haa_bbcc;
        mem_pm[6] = 24'h11_2233;
        mem_pm[7] = 24'hdd_eeff;
        mem_dm[14'h3fe0] = 16'hbeef;
        mem_dm[14'h0020] = 16'hc0de;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_dm();
        t_pm();
        t_drop();
        t_misc();
        tally_and_finish();
    end
endmodule
bind hmp_host_memory_port hmp_host_memory_port_asserts i_chk (.clk(clk), .nrst(nrst),
    .port_select_n(port_select_n), .address_latch_enable(address_latch_enable),
    .read_strobe_n(read_strobe_n), .addr_data_bus_oe(addr_data_bus_oe),
    .access_ack_n(access_ack_n), .core_ctrl_we(core_ctrl_we),
    .core_ctrl_wdata(core_ctrl_wdata), .core_ctrl_rdata(core_ctrl_rdata),
    .overlay_page(overlay_page), .mem_req(mem_req), .core_stall(core_stall));
`default_nettype wire
